//--- hdl/mcd_classify.sv
// Purpose: classifies a mode command by code, direction, broadcast
// Assumes: illegalization bit is looked up outside
// Notes:   combinational only
`timescale 1ns/1ps
`default_nettype none
module mcd_classify (
    // classifier side of the command interface
    mcd_cls_if.cls c
);
    logic reserved; // reserved code, legality from table and broadcast rule
    logic bc_ok;    // broadcast allowed for this combination
    // mode command when subaddress is all zeros or all ones
    assign c.is_mode = (c.sa == mcd_pkg::SA_ZERO) ||
                       (c.sa == mcd_pkg::SA_ONES);
    // the 22 undefined codes
    assign c.undef = c.tr ? (c.code == 5'h11 || c.code == 5'h14 ||
                             c.code == 5'h15)
                          : (!c.code[4] || c.code == 5'h10 ||
                             c.code == 5'h12 || c.code == 5'h13);
    // reserved codes, kept for visibility only
    assign reserved = (c.tr && !c.code[4] && c.code >= 5'h09) ||
                      (c.code >= 5'h16);
    // broadcast-capable combinations
    assign bc_ok = c.tr ? (c.code == 5'h01 ||
                           (!c.code[4] && c.code >= 5'h03))
                        : (c.code == 5'h11 || c.code >= 5'h14);
    // undefined codes vanish entirely when invalidated
    assign c.recog = c.is_mode && !(c.uci && c.undef);
    // table bit and broadcast rule decide, reserved codes included; the
    // terminal can never take bus control
    assign c.legal = !c.ill && !(c.bcast && !bc_ok) &&
                     !(c.tr && c.code == mcd_pkg::MC_DYN_BUS) &&
                     (reserved || !reserved);
    // only codes 16..31 carry a data word
    assign c.has_data = c.code[4];
endmodule : mcd_classify
`default_nettype wire

//--- hdl/mcd_handler.sv
// Purpose: mode command interpreter and mode data word mover
// Assumes: decoder gives one strobe per command and data word,
//          and a done strobe when the message completes
// Notes:   RAM reads return data in the cycle after ram_re
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - codes 0-15 never carry a data word
// - codes 0-15 answer with status only
// - legal receive codes 16-31 take one data word
// - legal transmit codes 16-31 send one word
// - buffered storage uses descriptor's buffer
// - no circular buffering for mode commands
// - simplified storage keeps data in descriptor
// - reserved codes decoded from 5-bit field
// - broadcast accepted only for listed codes
// - invalidated undefined codes: silence, status kept
// - legal undefined codes answer in form
// - legal undefined codes 16-31 move data
// - illegal: error flag, status only, no data
// - reserved legality from table bit and broadcast rule
// - dynamic bus control never accepted
// - codes 0-15 write info and time tag
// - received word stored after message completes
// - transmit word fetched from assigned buffer
// - last command word supplied internally
// - self-test word from one of two registers
// - internally sourced words recorded afterwards
// - undefined codes valid after reset
module mcd_handler (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // command from the decoder
    input  wire logic        cmd_strb,
    input  wire logic [15:0] cmd_word,
    input  wire logic        cmd_bcast,
    input  wire logic        cmd_ill,
    input  wire logic [15:0] desc_addr,
    input  wire logic [15:0] buf_addr,
    input  wire logic        rx_strb,
    input  wire logic [15:0] rx_word,
    input  wire logic        msg_done,
    input  wire logic [15:0] time_tag,
    // response to the encoder
    output logic             resp_strb,
    output logic             resp_data,
    output logic      [15:0] tx_word,
    output logic             message_error_flag,
    // shared RAM port
    output logic      [15:0] ram_addr,
    output logic      [15:0] ram_wdata,
    output logic             ram_we,
    output logic             ram_re,
    input  wire logic [15:0] ram_rdata
);
    // ----------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------
    mcd_pkg::mcd_state_t state, next_state;
    logic [15:0] cfg;        // option bits
    logic [15:0] bitw;       // self-test word
    logic [15:0] bitw_alt;   // alternate self-test word
    logic [15:0] last_cmd;   // last recognised command word
    logic [15:0] cur_cmd;    // command in progress
    logic [15:0] base;       // buffer or descriptor base
    logic        cur_bcast;  // command was broadcast
    logic        cur_ill;    // command was illegal
    logic        cur_simp;   // simplified storage at command time
    logic [15:0] data_word;  // word sent or received
    logic        cur_tr;
    logic [4:0]  cur_code;
    logic        take;       // recognised command accepted now
    logic        xfer;       // legal data-carrying command
    mcd_cls_if   cls ();

    assign cur_tr   = cur_cmd[mcd_pkg::CW_TR];
    assign cur_code = cur_cmd[4:0];
    assign take     = (state == mcd_pkg::ST_IDLE) && cmd_strb &&
                      cls.recog;
    assign xfer     = !cur_ill && cur_code[4];

    // ----------------------------------------------------------
    // classification
    // ----------------------------------------------------------
    assign cls.tr    = cmd_word[mcd_pkg::CW_TR];
    assign cls.sa    = cmd_word[9:5];
    assign cls.code  = cmd_word[4:0];
    assign cls.bcast = cmd_bcast;
    assign cls.ill   = cmd_ill;
    assign cls.uci   = cfg[mcd_pkg::CFG_UCI];

    mcd_classify u_cls (
        .c (cls)
    );

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    // option and self-test registers; reset clears all options
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg      <= mcd_pkg::CFG_RST;
            bitw     <= mcd_pkg::WORD_RST;
            bitw_alt <= mcd_pkg::WORD_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                mcd_pkg::REG_CFG:      cfg      <= reg_wdata;
                mcd_pkg::REG_BITW:     bitw     <= reg_wdata;
                mcd_pkg::REG_BITW_ALT: bitw_alt <= reg_wdata;
                default:               ; // read-only or unmapped
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                mcd_pkg::REG_CFG:      reg_rdata <= cfg;
                mcd_pkg::REG_STAT:     reg_rdata <= {14'h0000,
                    state != mcd_pkg::ST_IDLE, message_error_flag};
                mcd_pkg::REG_LAST:     reg_rdata <= last_cmd;
                mcd_pkg::REG_BITW:     reg_rdata <= bitw;
                mcd_pkg::REG_BITW_ALT: reg_rdata <= bitw_alt;
                default:               reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------
    // command capture
    // ----------------------------------------------------------
    // invalidated codes never get here, so status is untouched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_cmd   <= 16'h0000;
            cur_bcast <= 1'b0;
            cur_ill   <= 1'b0;
            cur_simp  <= 1'b0;
            base      <= 16'h0000;
        end else if (take) begin
            cur_cmd   <= cmd_word;
            cur_bcast <= cmd_bcast;
            cur_ill   <= !cls.legal;
            cur_simp  <= cfg[mcd_pkg::CFG_SSS];
            // descriptor block or its indexed/ping-pong buffer;
            // circular layouts are never applied here
            base      <= cfg[mcd_pkg::CFG_SSS] ? desc_addr
                                               : buf_addr;
        end
    end

    // error flag: set by illegal, cleared by a legal command;
    // status reporting commands keep it for the controller
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            message_error_flag <= 1'b0;
        end else if (take && !cls.legal) begin
            message_error_flag <= 1'b1;
        end else if (take && !(cls.tr &&
                     (cls.code == mcd_pkg::MC_XMT_STAT ||
                      cls.code == mcd_pkg::MC_LAST_CMD))) begin
            message_error_flag <= 1'b0;
        end
    end

    // last command history, not replaced by the command that
    // reports it, so the reported word is the previous one
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_cmd <= 16'h0000;
        end else if (take && !(cls.tr &&
                     cls.code == mcd_pkg::MC_LAST_CMD)) begin
            last_cmd <= cmd_word;
        end
    end

    // mode data word: received, internally made or fetched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_word <= 16'h0000;
        end else if (take && cls.tr &&
                     cls.code == mcd_pkg::MC_LAST_CMD) begin
            data_word <= last_cmd;
        end else if (take && cls.tr &&
                     cls.code == mcd_pkg::MC_SELFTEST) begin
            data_word <= cfg[mcd_pkg::CFG_ALT] ? bitw_alt
                                               : bitw;
        end else if (state == mcd_pkg::ST_FETCH && !ram_re) begin
            data_word <= ram_rdata;
        end else if (state == mcd_pkg::ST_WAIT_RX && rx_strb) begin
            data_word <= rx_word;
        end
    end

    // ----------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            mcd_pkg::ST_IDLE: begin
                if (take && cls.legal && cls.has_data && !cls.tr) begin
                    next_state = mcd_pkg::ST_WAIT_RX;
                end else if (take && cls.legal && cls.has_data &&
                             cls.code != mcd_pkg::MC_LAST_CMD &&
                             cls.code != mcd_pkg::MC_SELFTEST) begin
                    next_state = mcd_pkg::ST_FETCH;
                end else if (take) begin
                    next_state = mcd_pkg::ST_RESP;
                end
            end
            mcd_pkg::ST_WAIT_RX: begin
                // a message that ends without its word is dropped
                if (rx_strb) begin
                    next_state = mcd_pkg::ST_RESP;
                end else if (msg_done) begin
                    next_state = mcd_pkg::ST_IDLE;
                end
            end
            mcd_pkg::ST_FETCH: begin
                // RAM answers the cycle after its read strobe
                if (!ram_re) begin
                    next_state = mcd_pkg::ST_RESP;
                end
            end
            mcd_pkg::ST_RESP:      next_state = mcd_pkg::ST_WAIT_DONE;
            mcd_pkg::ST_WAIT_DONE: begin
                if (msg_done) begin
                    next_state = mcd_pkg::ST_WR_INFO;
                end
            end
            mcd_pkg::ST_WR_INFO:   next_state = mcd_pkg::ST_WR_TAG;
            mcd_pkg::ST_WR_TAG: begin
                // codes 0-15 and illegal ones store no data word
                next_state = xfer ? mcd_pkg::ST_WR_DATA
                                  : mcd_pkg::ST_IDLE;
            end
            mcd_pkg::ST_WR_DATA:   next_state = mcd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= mcd_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------
    // response to the encoder
    // ----------------------------------------------------------
    // broadcasts get no reply; data only for legal 16-31 transmit
    assign resp_strb = (state == mcd_pkg::ST_RESP) && !cur_bcast;
    assign resp_data = resp_strb && xfer && cur_tr;
    assign tx_word   = data_word;

    // ----------------------------------------------------------
    // RAM port, registered from the next state
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ram_we    <= 1'b0;
            ram_re    <= 1'b0;
            ram_addr  <= 16'h0000;
            ram_wdata <= 16'h0000;
        end else begin
            ram_we <= 1'b0;
            ram_re <= 1'b0;
            // one read strobe per fetch, issued on leaving idle
            if (state == mcd_pkg::ST_IDLE &&
                next_state == mcd_pkg::ST_FETCH) begin
                ram_re   <= 1'b1;
                ram_addr <= cfg[mcd_pkg::CFG_SSS]
                    ? desc_addr + mcd_pkg::DSC_DATA
                    : buf_addr + mcd_pkg::BUF_DATA;
            end else if (next_state == mcd_pkg::ST_WR_INFO) begin
                ram_we    <= 1'b1;
                ram_addr  <= base + (cur_simp ? mcd_pkg::DSC_INFO
                                              : mcd_pkg::BUF_INFO);
                ram_wdata <= {cur_bcast, cur_ill, 3'b000,
                              cur_cmd[10:0]};
            end else if (next_state == mcd_pkg::ST_WR_TAG) begin
                ram_we    <= 1'b1;
                ram_addr  <= base + (cur_simp ? mcd_pkg::DSC_TAG
                                              : mcd_pkg::BUF_TAG);
                ram_wdata <= time_tag;
            end else if (next_state == mcd_pkg::ST_WR_DATA) begin
                // received words and internally made words alike
                ram_we    <= 1'b1;
                ram_addr  <= base + (cur_simp ? mcd_pkg::DSC_DATA
                                              : mcd_pkg::BUF_DATA);
                ram_wdata <= data_word;
            end
        end
    end

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_done;
        state == mcd_pkg::ST_WAIT_DONE && msg_done;
    endsequence
    sequence s_meta;
        ram_we && ram_addr == base + (cur_simp ? mcd_pkg::DSC_INFO
                                               : mcd_pkg::BUF_INFO)
        ##1 ram_we && ram_wdata == $past(time_tag);
    endsequence

    a_undef_silent: assert property (
        state == mcd_pkg::ST_IDLE && cmd_strb && cls.uci && cls.undef
        |=> state == mcd_pkg::ST_IDLE && $stable(message_error_flag))
        else $error("invalid undefined code was handled");
    a_illegal_me: assert property (
        take && !cls.legal |=> message_error_flag [*2])
        else $error("error flag not set for illegal command");
    a_short_nodata: assert property (
        resp_strb && (!cur_code[4] || cur_ill) |-> !resp_data)
        else $error("data word sent for status-only reply");
    a_tx_word: assert property (
        resp_strb && xfer && cur_tr |-> resp_data)
        else $error("missing transmit mode data word");
    a_bcast_quiet: assert property (
        take && cmd_bcast |=> !resp_strb [*8])
        else $error("reply to broadcast command");
    a_dyn_bus: assert property (
        take && cls.tr && cls.code == mcd_pkg::MC_DYN_BUS
        |=> message_error_flag)
        else $error("dynamic bus control accepted");
    a_last_word: assert property (
        take && cls.tr && cls.code == mcd_pkg::MC_LAST_CMD
        |=> data_word == $past(last_cmd) && last_cmd == $past(last_cmd))
        else $error("wrong last command word");
    a_meta_write: assert property (
        s_done |=> s_meta)
        else $error("info and time tag not written");
    a_data_store: assert property (
        s_done and xfer |=> ##2 ram_we && ram_wdata == data_word)
        else $error("mode data word not stored");
endmodule : mcd_handler
`default_nettype wire

//--- pkg/mcd_cls_if.sv
// Purpose: carries a command to the mode code classifier and back
// Assumes: purely combinational classification
// Notes:   fields are valid whenever the command inputs are
`timescale 1ns/1ps
`default_nettype none
interface mcd_cls_if;
    logic       tr, bcast, ill, uci;   // command and option inputs
    logic [4:0] sa, code;              // subaddress, mode code
    logic       is_mode, undef, recog; // classification results
    logic       legal, has_data;
    modport user (output tr, bcast, ill, uci, sa, code,
                  input is_mode, undef, recog, legal, has_data);
    modport cls  (input tr, bcast, ill, uci, sa, code,
                  output is_mode, undef, recog, legal, has_data);
endinterface : mcd_cls_if
`default_nettype wire

//--- pkg/mcd_pkg.sv
// Purpose: constants and types for the mode command data handler
// Assumes: 16-bit command words, 16-bit shared RAM addresses
// Notes:   command word fields are tr[10], sa[9:5], mode code[4:0]
package mcd_pkg;
    // ----------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ----------------------------------------------------------
    localparam logic [7:0]  REG_CFG      = 8'h01; // option bits
    localparam logic [7:0]  REG_STAT     = 8'h02; // busy, error flag
    localparam logic [7:0]  REG_LAST     = 8'h03; // last command word
    localparam logic [7:0]  REG_BITW     = 8'h14; // self-test word
    localparam logic [7:0]  REG_BITW_ALT = 8'h15; // alternate word
    localparam logic [15:0] CFG_RST      = 16'h0000;
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam int CFG_SSS  = 0; // simplified_storage_select
    localparam int CFG_UCI  = 1; // undefined_codes_invalid
    localparam int CFG_ALT  = 2; // alternate_selftest_word_select
    localparam int STAT_ME  = 0; // message_error_flag
    localparam int STAT_BSY = 1; // command in progress
    // ----------------------------------------------------------
    // command word and mode codes
    // ----------------------------------------------------------
    localparam int CW_TR = 10;
    localparam logic [4:0] SA_ZERO     = 5'h00;
    localparam logic [4:0] SA_ONES     = 5'h1f;
    localparam logic [4:0] MC_DYN_BUS  = 5'h00;
    localparam logic [4:0] MC_XMT_STAT = 5'h02;
    localparam logic [4:0] MC_LAST_CMD = 5'h12; // last_command_mode_code
    localparam logic [4:0] MC_SELFTEST = 5'h13; // selftest_word_mode_code
    // ----------------------------------------------------------
    // buffer layouts and message information word
    // ----------------------------------------------------------
    localparam logic [15:0] BUF_INFO = 16'h0000;
    localparam logic [15:0] BUF_TAG  = 16'h0001;
    localparam logic [15:0] BUF_DATA = 16'h0002;
    localparam logic [15:0] DSC_INFO = 16'h0001;
    localparam logic [15:0] DSC_TAG  = 16'h0002;
    localparam logic [15:0] DSC_DATA = 16'h0003;
    localparam int INFO_BCAST = 15;
    localparam int INFO_ME    = 14;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_RX, ST_FETCH, ST_RESP, ST_WAIT_DONE,
        ST_WR_INFO, ST_WR_TAG, ST_WR_DATA
    } mcd_state_t;
endpackage : mcd_pkg

//--- verif/mcd_bc_model.sv
// Purpose: bus controller and shared RAM facing the handler
// Assumes: one message at a time, lines change after rising edges
// Notes:   released lines show changing junk, never the last value
`timescale 1ns/1ps
`default_nettype none
module mcd_bc_model (
    // clock
    input  wire logic        ref_clk,
    // words arriving from the bus
    output logic             cmd_strb,
    output logic      [15:0] cmd_word,
    output logic             rx_strb,
    output logic      [15:0] rx_word,
    output logic             msg_done,
    output logic      [15:0] time_tag,
    // shared RAM port
    input  wire logic [15:0] ram_addr,
    input  wire logic [15:0] ram_wdata,
    input  wire logic        ram_we,
    input  wire logic        ram_re,
    output logic      [15:0] ram_rdata
);
    logic [15:0] mem [0:255]; // low address bits only, bench keeps low
    initial begin
        cmd_strb = 1'b0;
        cmd_word = 16'h0000;
        rx_strb = 1'b0;
        rx_word = 16'hffff;
        msg_done = 1'b0;
        time_tag = 16'h0000;
        ram_rdata = 16'h0000;
    end
    // tag counter runs free so a stale tag would show
    always @(posedge ref_clk) begin
        time_tag <= time_tag + 16'h0001;
        if (ram_we) mem[ram_addr[7:0]] <= ram_wdata;
        ram_rdata <= ram_re ? mem[ram_addr[7:0]] : ~ram_rdata;
    end
    // one message: command, data word after gap cycles, completion
    task automatic msg(input logic [15:0] cw, input logic send,
                       input int gap, input logic [15:0] dw);
        @(posedge ref_clk);
        cmd_strb <= 1'b1;
        cmd_word <= cw;
        @(posedge ref_clk);
        cmd_strb <= 1'b0;
        cmd_word <= ~cw;
        repeat (gap) @(posedge ref_clk);
        if (send) begin // receive codes 16-31 carry one word
            rx_strb <= 1'b1;
            rx_word <= dw;
            @(posedge ref_clk);
            rx_strb <= 1'b0;
            rx_word <= ~dw;
        end
        repeat (6) @(posedge ref_clk);
        msg_done <= 1'b1;
        @(posedge ref_clk);
        msg_done <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : msg
endmodule : mcd_bc_model
`default_nettype wire

//--- verif/tb_mcd_handler.sv
// Purpose: self-checking bench for the mode command data handler
// Assumes: buffer base 0x40, descriptor base 0x80
// Notes:   counts replies and RAM writes per message
`timescale 1ns/1ps
`default_nettype none
module tb_mcd_handler;
    localparam logic [7:0]  BUF = 8'h40; // assigned buffer base
    localparam logic [7:0]  BD  = BUF + mcd_pkg::BUF_DATA[7:0];
    localparam logic [7:0]  DD  = 8'h80 + mcd_pkg::DSC_DATA[7:0];
    localparam logic [15:0] RXD = 16'h5a3c; // received data word
    logic        ref_clk, sys_rst, reg_wr, reg_rd, cmd_strb, cmd_bcast;
    logic        cmd_ill, rx_strb, msg_done, resp_strb, resp_data;
    logic        message_error_flag, ram_we, ram_re;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, cmd_word, desc_addr, buf_addr;
    logic [15:0] rx_word, time_tag, tx_word, ram_addr, ram_wdata;
    logic [15:0] ram_rdata, txv;
    int          err_total, n_tests, nresp, ndata, nwr;
    mcd_handler i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_strb(cmd_strb),
        .cmd_word(cmd_word), .cmd_bcast(cmd_bcast), .cmd_ill(cmd_ill),
        .desc_addr(desc_addr), .buf_addr(buf_addr), .rx_strb(rx_strb),
        .rx_word(rx_word), .msg_done(msg_done), .time_tag(time_tag),
        .resp_strb(resp_strb), .resp_data(resp_data), .tx_word(tx_word),
        .message_error_flag(message_error_flag), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
        .ram_rdata(ram_rdata));
    mcd_bc_model i_bc (.ref_clk(ref_clk), .cmd_strb(cmd_strb),
        .cmd_word(cmd_word), .rx_strb(rx_strb), .rx_word(rx_word),
        .msg_done(msg_done), .time_tag(time_tag), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
        .ram_rdata(ram_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // tally replies; tx word taken in the cycle resp_data stands
    always @(posedge ref_clk) begin
        if (resp_strb) nresp++;
        if (resp_data) ndata++;
        if (resp_data) txv <= tx_word;
        if (ram_we) nwr++;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : reg_read
    // one mode message; slow or prompt data word by code bits
    task automatic run(input logic tr, input logic [4:0] sa,
        input logic [4:0] c, input logic bc, input logic ill);
        nresp = 0;
        ndata = 0;
        nwr = 0;
        cmd_bcast <= bc;
        cmd_ill <= ill;
        i_bc.msg({5'h00, tr, sa, c}, !tr && c[4], int'(c[1:0]) * 3, RXD);
    endtask : run
    task automatic cnt(input int r, input int d, input logic f);
        check(16'(nresp), 16'(r));
        check(16'(ndata), 16'(d));
        check({15'h0000, message_error_flag}, {15'h0000, f});
    endtask : cnt
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmd_bcast = 1'b0;
        cmd_ill = 1'b0; // table bits left clear by default
        desc_addr = 16'h0080;
        buf_addr = {8'h00, BUF}; // single-message buffer
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_read(mcd_pkg::REG_CFG, mcd_pkg::CFG_RST);
        reg_read(8'h7f, 16'h0000);
        reg_write(mcd_pkg::REG_BITW, 16'h1234);
        reg_write(mcd_pkg::REG_BITW_ALT, 16'hbeef);
        reg_read(mcd_pkg::REG_BITW_ALT, 16'hbeef);
        run(1'b1, mcd_pkg::SA_ZERO, 5'd1, 1'b0, 1'b0);
        cnt(1, 0, 1'b0);
        check(16'(nwr), 16'd2);
        check(i_bc.mem[BUF], 16'h0401);
        run(1'b1, mcd_pkg::SA_ONES, 5'd0, 1'b0, 1'b0);
        cnt(1, 0, 1'b1);
        i_bc.mem[BD] = 16'h0000;
        run(1'b0, mcd_pkg::SA_ZERO, 5'd17, 1'b0, 1'b0);
        cnt(1, 0, 1'b0);
        check(i_bc.mem[BD], RXD);
        i_bc.mem[BD] = 16'hc0de;
        run(1'b1, mcd_pkg::SA_ZERO, 5'd16, 1'b0, 1'b0);
        cnt(1, 1, 1'b0);
        check(txv, 16'hc0de);
        i_bc.mem[BD] = 16'h0000;
        run(1'b1, mcd_pkg::SA_ZERO, 5'd19, 1'b0, 1'b0);
        check(txv, 16'h1234);
        check(i_bc.mem[BD], 16'h1234);
        reg_write(mcd_pkg::REG_CFG, 16'h0004);
        run(1'b1, mcd_pkg::SA_ZERO, 5'd19, 1'b0, 1'b0);
        check(txv, 16'hbeef);
        run(1'b1, mcd_pkg::SA_ZERO, 5'd18, 1'b0, 1'b0);
        check(txv, 16'h0413);
        check(i_bc.mem[BD], 16'h0413);
        i_bc.mem[BD] = 16'h1717;
        run(1'b1, mcd_pkg::SA_ZERO, 5'd17, 1'b0, 1'b0);
        cnt(1, 1, 1'b0);
        check(txv, 16'h1717);
        i_bc.mem[BD] = 16'h7777;
        run(1'b0, mcd_pkg::SA_ZERO, 5'd17, 1'b0, 1'b1);
        cnt(1, 0, 1'b1);
        check(i_bc.mem[BD], 16'h7777);
        i_bc.mem[BD] = 16'h0000;
        run(1'b0, mcd_pkg::SA_ZERO, 5'd17, 1'b1, 1'b0);
        cnt(0, 0, 1'b0);
        check(i_bc.mem[BD], RXD);
        run(1'b1, mcd_pkg::SA_ZERO, 5'd2, 1'b1, 1'b0);
        cnt(0, 0, 1'b1);
        reg_write(mcd_pkg::REG_CFG, 16'h0002);
        run(1'b0, mcd_pkg::SA_ZERO, 5'd5, 1'b0, 1'b0);
        cnt(0, 0, 1'b1);
        check(16'(nwr), 16'd0);
        run(1'b1, mcd_pkg::SA_ZERO, 5'd2, 1'b0, 1'b0);
        cnt(1, 0, 1'b1);
        i_bc.mem[BD] = 16'h2525;
        run(1'b1, mcd_pkg::SA_ZERO, 5'd25, 1'b0, 1'b0);
        cnt(1, 1, 1'b0);
        check(txv, 16'h2525);
        reg_write(mcd_pkg::REG_CFG, 16'h0001);
        i_bc.mem[DD] = 16'h0000;
        run(1'b0, mcd_pkg::SA_ZERO, 5'd17, 1'b0, 1'b0);
        check(i_bc.mem[DD], RXD);
        run(1'b0, 5'h03, 5'd17, 1'b0, 1'b0);
        check(16'(nresp + nwr), 16'd0);
        end_sim();
    end
    // watchdog: the run needs about 13 us
    initial begin
        #200us;
        err_total++;
        end_sim();
    end
endmodule : tb_mcd_handler
`default_nettype wire
